//--- hw/adc_output_port_config.sv
// Output port configuration registers, sample FIFO and output clock and data stage.
`timescale 1ns/10ps
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic push, pop, next_ready;

  // Ready is registered from the next pointers, so it leaves on a flop without losing a cycle.
  always_comb begin
    out_valid_out = wr_ptr != rd_ptr;
    out_data_out = mem[rd_ptr[PW-1:0]];
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_ready = (next_wr_ptr - next_rd_ptr) != (PW+1)'(DEPTH);
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      in_ready_out <= 1'b1;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      in_ready_out <= next_ready;
    end
  end

  // Storage carries no reset so it can map onto plain memory.
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr[PW-1:0]] <= in_data_in;
    end
  end
endmodule : sample_fifo

// Notes on behaviour
// - Format field 00/11 offset binary, 01 twos complement, 10 Gray; reset offset binary.
// - Top two format bits pick output level, 00 for 3.3 V, 10 for 1.8 V.
// - Each drive field selects one to four stripes; reset gives three stripes.
// - Phase bit 7 set drives the output data clock inverted, clear drives it normally.
// - Phase adjust field delays the output clock by that many input clock cycles.
// - With the divider active, phase adjust picks the divider phase; latching is unchanged.
// - Fine delay code steps 0.56 ns, enabled for clock by bit 7, data by bit 5.
// - Fine delay moves only pin timing, never internal sampling or processing.
// - First user pattern is 16 bits, low byte at 0x19, high at 0x1A, reset zero.
// - Test mode 1000 puts the stored user pattern on the outputs instead of samples, inverted when format bit 2 is set.
module adc_output_port_config
  import adc_out_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [2:0] clk_div_ratio_in,
  input wire logic [3:0] test_mode_in,
  input wire logic sample_valid_in,
  output logic sample_ready_out,
  input wire logic [DATA_W-1:0] sample_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe_out,
  output logic output_data_clock_out,
  output logic [1:0] output_level_out,
  output logic [1:0] drive_a_out,
  output logic [1:0] drive_b_out,
  output logic clock_fine_en_out,
  output logic data_fine_en_out,
  output logic [2:0] fine_code_out
);
  logic [7:0] format_control, drive_strength, clock_phase, fine_delay, patt_low, patt_high;
  logic [7:0] next_format, next_drive, next_phase, next_fine, next_patt_low, next_patt_high;
  logic [7:0] next_rdata;
  logic [2:0] div_cnt, next_div_cnt, half;
  logic [6:0] clk_hist, next_clk_hist;
  logic tick, raw_clk, tapped, next_out_clk;
  logic [DATA_W-1:0] next_data, formatted, pattern, fifo_data;
  logic fifo_valid;
  logic [7:0] ph_taps;

  assign pattern = {patt_high, patt_low};

  // Register file: writes are masked so open bits always read back as zero.
  always_comb begin
    next_format = format_control;
    next_drive = drive_strength;
    next_phase = clock_phase;
    next_fine = fine_delay;
    next_patt_low = patt_low;
    next_patt_high = patt_high;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        ADDR_FORMAT: next_format = reg_wdata_in & MASK_FORMAT;
        ADDR_DRIVE: next_drive = reg_wdata_in & MASK_DRIVE;
        ADDR_PHASE: next_phase = reg_wdata_in & MASK_PHASE;
        ADDR_FINE: next_fine = reg_wdata_in & MASK_FINE;
        ADDR_PATT_LOW: next_patt_low = reg_wdata_in;
        ADDR_PATT_HIGH: next_patt_high = reg_wdata_in;
        default: next_format = format_control;
      endcase
    end
    next_rdata = 8'h00;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        ADDR_FORMAT: next_rdata = format_control;
        ADDR_DRIVE: next_rdata = drive_strength;
        ADDR_PHASE: next_rdata = clock_phase;
        ADDR_FINE: next_rdata = fine_delay;
        ADDR_PATT_LOW: next_rdata = patt_low;
        ADDR_PATT_HIGH: next_rdata = patt_high;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      format_control <= RST_FORMAT;
      drive_strength <= RST_DRIVE;
      clock_phase <= RST_PHASE;
      fine_delay <= RST_FINE;
      patt_low <= RST_PATT;
      patt_high <= RST_PATT;
      reg_rdata_out <= 8'h00;
    end else begin
      format_control <= next_format;
      drive_strength <= next_drive;
      clock_phase <= next_phase;
      fine_delay <= next_fine;
      patt_low <= next_patt_low;
      patt_high <= next_patt_high;
      reg_rdata_out <= next_rdata;
    end
  end

  // Pin-side settings leave the chip as registered levels for the pad ring.
  assign output_level_out = format_control[FMT_LEVEL_POS +: 2];
  assign drive_a_out = drive_strength[DRV_A_POS +: 2];
  assign drive_b_out = drive_strength[DRV_B_POS +: 2];
  assign clock_fine_en_out = fine_delay[FD_CLK_EN_BIT];
  assign data_fine_en_out = fine_delay[FD_DATA_EN_BIT];
  // Sub-cycle delay is done in the pad delay line, so sampling here never moves.
  assign fine_code_out = fine_delay[FD_CODE_POS +: 3];

  sample_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .in_valid_in(sample_valid_in),
    .in_ready_out(sample_ready_out),
    .in_data_in(sample_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(tick),
    .out_data_out(fifo_data)
  );

  // Word formatting; the core delivers offset binary.
  always_comb begin
    unique case (format_control[FMT_CODE_POS +: 2])
      CODE_TWOS: formatted = {~fifo_data[DATA_W-1], fifo_data[DATA_W-2:0]};
      CODE_GRAY: formatted = fifo_data ^ (fifo_data >> 1);
      default: formatted = fifo_data;
    endcase
    if (test_mode_in == TEST_USER) begin
      formatted = pattern;
    end
    if (format_control[FMT_INVERT_BIT]) begin
      formatted = ~formatted;
    end
    next_data = data_out;
    if (tick && (fifo_valid || test_mode_in == TEST_USER)) begin
      next_data = formatted;
    end
  end

  // Divider and output clock. The sample strobe is fixed by the divider alone
  // so phase and polarity only move the clock seen at the pin.
  always_comb begin
    tick = div_cnt == 3'h0;
    next_div_cnt = (div_cnt >= clk_div_ratio_in) ? 3'h0 : div_cnt + 3'h1;
    half = 3'((4'(clk_div_ratio_in) + 4'h2) >> 1);
    // With divide by one raw_clk stays high, so the pin clock is held at a constant level here.
    raw_clk = div_cnt < half;
    next_clk_hist = {clk_hist[5:0], raw_clk};
    ph_taps = {clk_hist, raw_clk};
    tapped = ph_taps[clock_phase[PH_ADJUST_POS +: 3]];
    next_out_clk = tapped ^ clock_phase[PH_POLARITY_BIT];
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      div_cnt <= 3'h0;
      clk_hist <= 7'h00;
      output_data_clock_out <= 1'b0;
      data_out <= 16'h0000;
      data_oe_out <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      clk_hist <= next_clk_hist;
      output_data_clock_out <= next_out_clk;
      data_out <= next_data;
      data_oe_out <= !format_control[FMT_DISABLE_BIT];
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_twos_format: assert property (
    tick && fifo_valid && test_mode_in != TEST_USER && format_control[1:0] == CODE_TWOS
      && !format_control[FMT_INVERT_BIT]
    |=> data_out == {~$past(fifo_data[15]), $past(fifo_data[14:0])})
    else $error("Twos complement word wrong.");
  a_gray_format: assert property (
    tick && fifo_valid && test_mode_in != TEST_USER && format_control[1:0] == CODE_GRAY
      && !format_control[FMT_INVERT_BIT]
    |=> data_out == ($past(fifo_data) ^ ($past(fifo_data) >> 1)))
    else $error("Gray word wrong.");
  a_level_write: assert property (
    reg_wr_in && reg_addr_in == ADDR_FORMAT |=> output_level_out == $past(reg_wdata_in[7:6]))
    else $error("Output level not taken.");
  a_disable_oe: assert property (
    format_control[FMT_DISABLE_BIT] |=> !data_oe_out)
    else $error("Outputs not disabled.");
  a_drive_write: assert property (
    reg_wr_in && reg_addr_in == ADDR_DRIVE
    |=> drive_a_out == $past(reg_wdata_in[1:0]) && drive_b_out == $past(reg_wdata_in[5:4]))
    else $error("Drive fields not taken.");
  a_clock_polarity: assert property (
    !$past(rst_in) && $past(clock_phase[2:0]) == 3'h0 |-> output_data_clock_out
      == ($past(raw_clk) ^ $past(clock_phase[PH_POLARITY_BIT])))
    else $error("Clock polarity wrong.");
  a_phase_three: assert property (
    $past(clock_phase[2:0]) == 3'h3 && !$past(clock_phase[PH_POLARITY_BIT])
    |-> output_data_clock_out == $past(raw_clk, 4))
    else $error("Clock phase delay wrong.");
  a_fine_write: assert property (
    reg_wr_in && reg_addr_in == ADDR_FINE
    |=> clock_fine_en_out == $past(reg_wdata_in[7]) && data_fine_en_out == $past(reg_wdata_in[5])
      && fine_code_out == $past(reg_wdata_in[2:0]))
    else $error("Fine delay not taken.");
  a_user_pattern: assert property (
    tick && test_mode_in == TEST_USER && !format_control[FMT_INVERT_BIT]
    |=> data_out == $past(pattern))
    else $error("User pattern not driven.");
  a_pattern_read: assert property (
    reg_rd_in && reg_addr_in == ADDR_PATT_HIGH |=> reg_rdata_out == $past(patt_high))
    else $error("Pattern high byte read wrong.");

  c_fifo_full: cover property (!sample_ready_out);
  c_user_mode: cover property (tick && test_mode_in == TEST_USER);
  c_inverted_clock: cover property (clock_phase[PH_POLARITY_BIT] && clock_phase[2:0] == 3'h7);
endmodule : adc_output_port_config
`default_nettype wire

//--- inc/adc_out_pkg.sv
// Package with register map, field layout and reset values of the output port block.
`default_nettype none
package adc_out_pkg;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_FORMAT = 8'h14;
  localparam logic [7:0] ADDR_DRIVE = 8'h15;
  localparam logic [7:0] ADDR_PHASE = 8'h16;
  localparam logic [7:0] ADDR_FINE = 8'h17;
  localparam logic [7:0] ADDR_PATT_LOW = 8'h19;
  localparam logic [7:0] ADDR_PATT_HIGH = 8'h1a;
  localparam logic [7:0] RST_FORMAT = 8'h00;
  localparam logic [7:0] RST_DRIVE = 8'h22;
  localparam logic [7:0] RST_PHASE = 8'h00;
  localparam logic [7:0] RST_FINE = 8'h00;
  localparam logic [7:0] RST_PATT = 8'h00;
  localparam logic [7:0] MASK_FORMAT = 8'hd7;
  localparam logic [7:0] MASK_DRIVE = 8'h33;
  localparam logic [7:0] MASK_PHASE = 8'h87;
  localparam logic [7:0] MASK_FINE = 8'ha7;
  localparam int FMT_LEVEL_POS = 6;
  localparam int FMT_DISABLE_BIT = 4;
  localparam int FMT_INVERT_BIT = 2;
  localparam int FMT_CODE_POS = 0;
  localparam int DRV_A_POS = 0;
  localparam int DRV_B_POS = 4;
  localparam int PH_POLARITY_BIT = 7;
  localparam int PH_ADJUST_POS = 0;
  localparam int FD_CLK_EN_BIT = 7;
  localparam int FD_DATA_EN_BIT = 5;
  localparam int FD_CODE_POS = 0;
  localparam int FINE_STEP_PS = 560;
  localparam logic [1:0] CODE_OFFSET = 2'h0;
  localparam logic [1:0] CODE_TWOS = 2'h1;
  localparam logic [1:0] CODE_GRAY = 2'h2;
  localparam logic [3:0] TEST_USER = 4'h8;
endpackage : adc_out_pkg
`default_nettype wire

//--- test/out_capture.sv
// Receiving logic model that captures output words on the output data clock.
`timescale 1ns/10ps
`default_nettype none
module out_capture (
  input wire logic dclk_in,
  input wire logic oe_in,
  input wire logic [15:0] data_in,
  output logic [15:0] word_out
);
  // Capture needs a phase delay set, since an undelayed edge lands with the data change.
  initial begin
    word_out = 16'h0000;
    forever begin
      @(posedge dclk_in);
      if (oe_in === 1'b1) begin
        word_out <= data_in;
      end
    end
  end
endmodule : out_capture
`default_nettype wire

//--- test/test_adc_output_port_config.sv
// Testbench for the output port configuration block.
`timescale 1ns/10ps
`default_nettype none
module test_adc_output_port_config;
  import adc_out_pkg::*;
  logic clk_sys_in, rst_in, reg_wr_in, reg_rd_in, sample_valid_in, sample_ready_out;
  logic data_oe_out, output_data_clock_out, clock_fine_en_out, data_fine_en_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic [2:0] clk_div_ratio_in, fine_code_out;
  logic [3:0] test_mode_in;
  logic [15:0] sample_in, data_out, cap_word;
  logic [1:0] output_level_out, drive_a_out, drive_b_out;
  int n_errors = 0;
  int n_checks = 0;
  int m0, m3, n;
  adc_output_port_config i_adc_output_port_config (.clk_sys_in, .rst_in, .reg_wr_in,
    .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .clk_div_ratio_in,
    .test_mode_in, .sample_valid_in, .sample_ready_out, .sample_in, .data_out, .data_oe_out,
    .output_data_clock_out, .output_level_out, .drive_a_out, .drive_b_out,
    .clock_fine_en_out, .data_fine_en_out, .fine_code_out);
  out_capture i_out_capture (.dclk_in(output_data_clock_out), .oe_in(data_oe_out),
    .data_in(data_out), .word_out(cap_word));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge clk_sys_in);
    reg_wr_in = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys_in);
    reg_rd_in = 1'b1;
    reg_addr_in = a;
    @(negedge clk_sys_in);
    reg_rd_in = 1'b0;
    d = reg_rdata_out;
  endtask : rd
  task automatic push(input logic [15:0] v);
    @(negedge clk_sys_in);
    sample_valid_in = 1'b1;
    sample_in = v;
    @(negedge clk_sys_in);
    sample_valid_in = 1'b0;
  endtask : push
  function automatic logic [15:0] fmt(input logic [15:0] x, input logic [2:0] c);
    logic [15:0] r;
    r = (c[1:0] == CODE_TWOS) ? (x ^ 16'h8000) : (c[1:0] == CODE_GRAY) ? (x ^ (x >> 1)) : x;
    return c[2] ? ~r : r;
  endfunction : fmt
  // One less than the cycles from a data change to the next rising output clock edge after it.
  task automatic lag(input logic [2:0] p, input logic [15:0] v, output int k);
    logic [15:0] d0;
    logic prev;
    wr(ADDR_PHASE, {5'h00, p});
    repeat (10) @(negedge clk_sys_in);
    d0 = data_out;
    push(v);
    for (k = 0; k < 30 && data_out === d0; k++) @(negedge clk_sys_in);
    prev = output_data_clock_out;
    for (k = 0; k < 12; k++) begin
      @(negedge clk_sys_in);
      if (output_data_clock_out === 1'b1 && prev === 1'b0) break;
      prev = output_data_clock_out;
    end
  endtask : lag
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #(8 * 20000);
    n_errors++;
    stop_test();
  end
  initial begin : main
    logic [7:0] d;
    logic [7:0] adr [6];
    logic [7:0] rstv [6];
    logic [7:0] msk [6];
    adr = '{ADDR_FORMAT, ADDR_DRIVE, ADDR_PHASE, ADDR_FINE, ADDR_PATT_LOW, ADDR_PATT_HIGH};
    rstv = '{RST_FORMAT, RST_DRIVE, RST_PHASE, RST_FINE, RST_PATT, RST_PATT};
    msk = '{MASK_FORMAT, MASK_DRIVE, MASK_PHASE, MASK_FINE, 8'hff, 8'hff};
    rst_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    clk_div_ratio_in = 3'h0;
    test_mode_in = 4'h0;
    sample_valid_in = 1'b0;
    sample_in = 16'h0000;
    repeat (8) @(negedge clk_sys_in);
    rst_in = 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(adr[i], d);
      chk(16'(d), 16'(rstv[i]));
    end
    chk(16'({drive_a_out, drive_b_out}), 16'h000a);
    $display("reset values test done");
    for (int i = 0; i < 6; i++) begin
      wr(adr[i], 8'hff);
      rd(adr[i], d);
      chk(16'(d), 16'(msk[i]));
    end
    wr(8'h18, 8'hff);
    rd(8'h18, d);
    chk(16'(d), 16'h0000);
    chk(16'({output_level_out, clock_fine_en_out, data_fine_en_out, fine_code_out}), 16'h007f);
    wr(ADDR_FORMAT, 8'h80);
    wr(ADDR_DRIVE, 8'h13);
    wr(ADDR_FINE, 8'h85);
    chk(16'({output_level_out, drive_a_out, drive_b_out, clock_fine_en_out, data_fine_en_out,
      fine_code_out}), 16'h05b5);
    $display("register access test done");
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_FORMAT, {5'h00, 3'(c)});
      push(16'h3a5c + 16'(c));
      repeat (6) @(negedge clk_sys_in);
      chk(data_out, fmt(16'h3a5c + 16'(c), 3'(c)));
    end
    wr(ADDR_FORMAT, 8'h00);
    wr(ADDR_PATT_LOW, 8'h5a);
    wr(ADDR_PATT_HIGH, 8'hc3);
    test_mode_in = TEST_USER;
    push(16'h1234);
    repeat (6) @(negedge clk_sys_in);
    chk(data_out, 16'hc35a);
    test_mode_in = 4'h0;
    wr(ADDR_FORMAT, 8'h10);
    repeat (3) @(negedge clk_sys_in);
    chk(16'(data_oe_out), 16'h0000);
    wr(ADDR_FORMAT, 8'h00);
    $display("data format test done");
    wr(ADDR_PHASE, 8'h80);
    repeat (10) @(negedge clk_sys_in);
    chk(16'(output_data_clock_out), 16'h0000);
    wr(ADDR_PHASE, 8'h00);
    repeat (10) @(negedge clk_sys_in);
    chk(16'(output_data_clock_out), 16'h0001);
    clk_div_ratio_in = 3'h7;
    lag(3'h0, 16'h1111, m0);
    lag(3'h3, 16'h2222, m3);
    chk(16'(m3), 16'((m0 + 3) % 8));
    $display("output clock test done");
    n = 0;
    @(negedge clk_sys_in);
    sample_valid_in = 1'b1;
    while (sample_ready_out === 1'b1 && n < 12) begin
      sample_in = 16'h4000 + 16'(n);
      @(negedge clk_sys_in);
      n++;
    end
    sample_valid_in = 1'b0;
    chk(16'(n >= 8 && n <= 10), 16'h0001);
    repeat (100) @(negedge clk_sys_in);
    chk(cap_word, 16'h4000 + 16'(n - 1));
    chk(16'(sample_ready_out), 16'h0001);
    $display("buffer test done");
    stop_test();
  end
endmodule : test_adc_output_port_config
`default_nettype wire
